// file: common/mdsl_pkg.sv
// Purpose: shared constants, encodings and state types of the management serial link
// Assumes: one start/opcode/address layout for both frame formats
// Notes: all widths are fixed; the host divider sets the generated bit clock rate
package mdsl_pkg;
    // field widths and sizes
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned REG_CNT = 32;
    // preamble length and field end counts used by the device counter
    localparam logic [5:0] PRE_CNT_FULL = 6'h20;
    localparam logic [5:0] CNT_RST = 6'h00;
    localparam logic [5:0] LAST2 = 6'h01;
    localparam logic [5:0] LAST5 = 6'h04;
    localparam logic [5:0] LAST16 = 6'h0F;
    // start patterns and opcodes
    localparam logic [1:0] ST_C22 = 2'h1;
    localparam logic [1:0] ST_C45 = 2'h0;
    localparam logic [1:0] OP22_RD = 2'h2;
    localparam logic [1:0] OP22_WR = 2'h1;
    localparam logic [1:0] OP45_ADDR = 2'h0;
    localparam logic [1:0] OP45_WR = 2'h1;
    localparam logic [1:0] OP45_RD = 2'h3;
    localparam logic [1:0] OP45_RDINC = 2'h2;
    // turnaround patterns and fillers
    localparam logic [1:0] TA_WR = 2'h2;
    localparam logic [1:0] TA_RD_IDLE = 2'h3;
    localparam logic [15:0] RD_FILL = 16'hFFFF;
    localparam logic [31:0] PRE_ONES = 32'hFFFF_FFFF;
    localparam logic [4:0] PHY_CONN_ADDR = 5'h00;
    // reset values
    localparam logic [15:0] C45_ADDR_RST = 16'h0000;
    localparam logic [15:0] MEM_RST = 16'h0000;
    localparam logic [2:0] DIV_RST = 3'h0;
    // host frame positions, counted from the first preamble bit
    localparam logic [6:0] IDX_PRE = 7'h00;
    localparam logic [6:0] IDX_NOPRE = 7'h20;
    localparam logic [6:0] HDR_END = 7'h2E;
    localparam logic [6:0] DATA_START = 7'h30;
    localparam logic [6:0] FRAME_BITS = 7'h40;
    localparam logic [6:0] FRAME_MSB = 7'h3F;
    // host bit clock: each half period lasts this many system clocks
    localparam int unsigned MDC_HALF_CYC = 4;
    localparam logic [2:0] MDC_HALF_LAST = 3'(MDC_HALF_CYC - 1);

    // device frame decoder states
    typedef enum logic [2:0] {
        DEV_PRE = 3'h0,
        DEV_ST = 3'h1,
        DEV_OP = 3'h2,
        DEV_PHY = 3'h3,
        DEV_REG = 3'h4,
        DEV_TA = 3'h5,
        DEV_DATA = 3'h6
    } mdsl_dev_st_e;

    // host sequencer states
    typedef enum logic [1:0] {
        HOST_IDLE = 2'h0,
        HOST_RUN = 2'h1,
        HOST_DONE = 2'h2
    } mdsl_host_st_e;

    // true when the device drives the data field back to the host
    function automatic logic mdsl_is_read(input logic c45, input logic [1:0] op);
        return c45 ? op[1] : (op == OP22_RD);
    endfunction
endpackage

// file: common/mdsl_link_if.sv
// Purpose: the two-wire management link between host end and device end
// Assumes: the line is pulled up whenever no end enables its driver
// Notes: resolution is done here so the design files hold no tristate
`timescale 1ns/1ps
`default_nettype none
interface mdsl_link_if;
    logic mdc;
    logic host_mdio_o;
    logic host_mdio_oe;
    logic dev_mdio_o;
    logic dev_mdio_oe;
    logic mdio;

    // wired line; the pull-up gives one when both drivers are off
    assign mdio = host_mdio_oe ? host_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'h1);

    modport host (output mdc, output host_mdio_o, output host_mdio_oe, input mdio);
    modport dev (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
endinterface
`default_nettype wire

// file: rtl/mdsl_dev_end.sv
// Purpose: device end of the management link; decodes frames on the link clock
// Assumes: cfg inputs are quasi-static; the host clocks the link and sends a preamble
// Notes: write results cross to clk_i by toggle with held data
//
// Overview of operation
// - line released whenever no frame is active
// - host sends 32 ones before each frame
// - respond only after 32 consecutive ones
// - host may skip preamble if slaves allow
// - fields follow preamble through data to idle
// - start zero then one marks short format
// - short format opcode 10 reads, 01 writes
// - five bit port address, msb first
// - connector slave also answers port zero
// - five bit register address, msb first
// - two bit turnaround separates address and data
// - first read turnaround bit left undriven
// - device drives zero in second read turnaround
// - host drives one then zero on writes
// - sixteen data bits, bit fifteen first
// - long format start 00 with four opcodes
// - address frame latches register address, others data
// - sample on rising edge, drive on falling
// - port and device address are configurable
`timescale 1ns/1ps
`default_nettype none
module mdsl_dev_end (
    // system side clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // link
    mdsl_link_if.dev link,
    // configuration
    input wire logic [mdsl_pkg::ADDR_W-1:0] cfg_phy_i,
    input wire logic [mdsl_pkg::ADDR_W-1:0] cfg_dev_i,
    input wire logic cfg_conn_i,
    // write report on clk_i
    output logic wr_valid_o,
    output logic wr_c45_o,
    output logic [mdsl_pkg::DATA_W-1:0] wr_addr_o,
    output logic [mdsl_pkg::DATA_W-1:0] wr_data_o
);
    import mdsl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // link domain state
    typedef struct packed {
        mdsl_dev_st_e st;
        logic [5:0] cnt;
        logic c45;
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] rega;
        logic [15:0] sh;
        logic [15:0] c45_addr;
        logic [10:0] cfg_m;
        logic [10:0] cfg_s;
        logic drv_oe;
        logic drv_bit;
        logic mem_we;
        logic [4:0] mem_idx;
        logic wr_tgl;
        logic wr_c45;
        logic [15:0] wr_addr;
        logic [15:0] wr_data;
    } mdsl_dev_link_s;

    // system domain state
    typedef struct packed {
        logic tgl_m;
        logic tgl_s;
        logic tgl_p;
        logic wr_valid;
        logic wr_c45;
        logic [15:0] wr_addr;
        logic [15:0] wr_data;
    } mdsl_dev_sys_s;

    localparam mdsl_dev_link_s LINK_RST = '{st: DEV_PRE, cnt: CNT_RST, c45_addr: C45_ADDR_RST,
                                            drv_bit: 1'h1, default: '0};
    localparam mdsl_dev_sys_s SYS_RST = '0;

    mdsl_dev_link_s q, d;
    mdsl_dev_sys_s qs, ds;
    logic [15:0] mem_q [REG_CNT];
    logic mdio_oe_q, mdio_out_q;
    logic [4:0] rega_n;
    logic [15:0] word_n, rdata;
    logic rd, match;

    ////////////////////////////////////////////////////////////////////////////
    // frame decoder, evaluated once per rising link clock edge
    always_comb begin
        d = q;
        d.mem_we = 1'h0;
        d.cfg_m = {cfg_conn_i, cfg_phy_i, cfg_dev_i};
        d.cfg_s = q.cfg_m;
        rega_n = {q.rega[3:0], link.mdio};
        word_n = {q.sh[14:0], link.mdio};
        rd = mdsl_is_read(q.c45, q.op);
        rdata = mem_q[q.c45 ? q.c45_addr[4:0] : q.rega];
        // port match, plus port zero when attached through the connector
        match = (q.phy == q.cfg_s[9:5]) || (q.cfg_s[10] && (q.phy == PHY_CONN_ADDR));
        if (q.c45) begin
            match = match && (rega_n == q.cfg_s[4:0]);
        end else begin
            match = match && ((q.op == OP22_RD) || (q.op == OP22_WR));
        end
        case (q.st)
            DEV_PRE: begin
                // a zero only starts a frame once the preamble is complete
                if (link.mdio) begin
                    if (q.cnt != PRE_CNT_FULL) begin
                        d.cnt = q.cnt + 6'h01;
                    end
                end else if (q.cnt == PRE_CNT_FULL) begin
                    d.st = DEV_ST;
                    d.cnt = CNT_RST;
                end else begin
                    d.cnt = CNT_RST;
                end
            end
            DEV_ST: begin
                d.c45 = (link.mdio == ST_C45[0]);
                d.st = DEV_OP;
            end
            DEV_OP: begin
                d.op = {q.op[0], link.mdio};
                d.cnt = q.cnt + 6'h01;
                if (q.cnt == LAST2) begin
                    d.st = DEV_PHY;
                    d.cnt = CNT_RST;
                end
            end
            DEV_PHY: begin
                d.phy = {q.phy[3:0], link.mdio};
                d.cnt = q.cnt + 6'h01;
                if (q.cnt == LAST5) begin
                    d.st = DEV_REG;
                    d.cnt = CNT_RST;
                end
            end
            DEV_REG: begin
                d.rega = rega_n;
                d.cnt = q.cnt + 6'h01;
                if (q.cnt == LAST5) begin
                    d.cnt = CNT_RST;
                    // a foreign frame is dropped after its register address; preamble counting restarts at once
                    d.st = match ? DEV_TA : DEV_PRE;
                end
            end
            DEV_TA: begin
                d.cnt = q.cnt + 6'h01;
                if (q.cnt == CNT_RST) begin
                    // first bit stays undriven; enable lands on the next fall
                    if (rd) begin
                        d.drv_oe = 1'h1;
                        d.drv_bit = 1'h0;
                        d.sh = rdata;
                    end
                end else begin
                    d.st = DEV_DATA;
                    d.cnt = CNT_RST;
                    if (rd) begin
                        d.drv_bit = q.sh[15];
                        d.sh = {q.sh[14:0], 1'h0};
                    end
                end
            end
            DEV_DATA: begin
                d.cnt = q.cnt + 6'h01;
                if (rd) begin
                    if (q.cnt != LAST16) begin
                        d.drv_bit = q.sh[15];
                        d.sh = {q.sh[14:0], 1'h0};
                    end else begin
                        d.drv_oe = 1'h0;
                        d.drv_bit = 1'h1;
                        d.st = DEV_PRE;
                        d.cnt = CNT_RST;
                        if (q.c45 && (q.op == OP45_RDINC)) begin
                            d.c45_addr = q.c45_addr + 16'h0001;
                        end
                    end
                end else begin
                    d.sh = word_n;
                    if (q.cnt == LAST16) begin
                        d.st = DEV_PRE;
                        d.cnt = CNT_RST;
                        if (q.c45 && (q.op == OP45_ADDR)) begin
                            d.c45_addr = word_n;
                        end else begin
                            d.mem_we = 1'h1;
                            d.mem_idx = q.c45 ? q.c45_addr[4:0] : q.rega;
                            d.wr_data = word_n;
                            d.wr_addr = q.c45 ? q.c45_addr : {11'h000, q.rega};
                            d.wr_c45 = q.c45;
                            d.wr_tgl = ~q.wr_tgl;
                        end
                    end
                end
            end
            default: begin
                d = LINK_RST;
            end
        endcase
    end

    // link state registers on the rising edge, where the line is sampled
    always_ff @(posedge link.mdc or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= LINK_RST;
        end else begin
            q <= d;
        end
    end

    // register storage; written at the edge that samples the last data bit,
    // since the bit clock rests between frames and a later edge may never come
    always_ff @(posedge link.mdc or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < REG_CNT; i++) begin
                mem_q[i] <= MEM_RST;
            end
        end else if (d.mem_we) begin
            mem_q[d.mem_idx] <= d.wr_data;
        end
    end

    // line driver changes on the falling edge so the host sees a settled bit
    always_ff @(negedge link.mdc or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdio_oe_q <= 1'h0;
            mdio_out_q <= 1'h1;
        end else begin
            mdio_oe_q <= q.drv_oe;
            mdio_out_q <= q.drv_bit;
        end
    end

    assign link.dev_mdio_oe = mdio_oe_q;
    assign link.dev_mdio_o = mdio_out_q;

    ////////////////////////////////////////////////////////////////////////////
    // write report crossing: toggle synchronised, data held stable for a frame
    always_comb begin
        ds = qs;
        ds.tgl_m = q.wr_tgl;
        ds.tgl_s = qs.tgl_m;
        ds.tgl_p = qs.tgl_s;
        ds.wr_valid = qs.tgl_s ^ qs.tgl_p;
        if (qs.tgl_s ^ qs.tgl_p) begin
            ds.wr_c45 = q.wr_c45;
            ds.wr_addr = q.wr_addr;
            ds.wr_data = q.wr_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            qs <= SYS_RST;
        end else begin
            qs <= ds;
        end
    end

    assign wr_valid_o = qs.wr_valid;
    assign wr_c45_o = qs.wr_c45;
    assign wr_addr_o = qs.wr_addr;
    assign wr_data_o = qs.wr_data;
endmodule // mdsl_dev_end
`default_nettype wire

// file: rtl/mdsl_host_end.sv
// Purpose: host end of the management link; makes the bit clock and runs one frame per command
// Assumes: clk_i at 25 MHz; the bit clock is clk_i divided by twice MDC_HALF_CYC
// Notes: the bit clock rests low between frames
`timescale 1ns/1ps
`default_nettype none
module mdsl_host_end (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // link
    mdsl_link_if.host link,
    // command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_c45_i,
    input wire logic cmd_pre_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [mdsl_pkg::ADDR_W-1:0] cmd_phy_i,
    input wire logic [mdsl_pkg::ADDR_W-1:0] cmd_reg_i,
    input wire logic [mdsl_pkg::DATA_W-1:0] cmd_data_i,
    // response
    output logic rsp_valid_o,
    output logic [mdsl_pkg::DATA_W-1:0] rsp_data_o
);
    import mdsl_pkg::*;

    typedef struct packed {
        mdsl_host_st_e st;
        logic [2:0] div;
        logic mdc;
        logic [6:0] idx;
        logic [63:0] frame;
        logic rd;
        logic oe;
        logic out;
        logic sync_m;
        logic sync_s;
        logic [15:0] rx;
        logic ready;
        logic rsp_valid;
        logic [15:0] rsp_data;
    } mdsl_host_s;

    localparam mdsl_host_s HOST_RST = '{st: HOST_IDLE, div: DIV_RST, out: 1'h1, default: '0};

    mdsl_host_s q;
    mdsl_host_s d;
    logic rd_n;

    ////////////////////////////////////////////////////////////////////////////
    // helpers shared by the first bit and the later falling edges
    function automatic logic tx_bit(input logic [63:0] frame, input logic [6:0] idx);
        logic [6:0] pos;
        pos = FRAME_MSB - idx;
        return frame[pos[5:0]];
    endfunction

    // on reads the host releases the line from the first turnaround bit on
    function automatic logic host_drives(input logic rd, input logic [6:0] idx);
        return !rd || (idx < HDR_END);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: drive after each fall, sample at each rise
    always_comb begin
        d = q;
        d.rsp_valid = 1'h0;
        d.sync_m = link.mdio;
        d.sync_s = q.sync_m;
        rd_n = mdsl_is_read(cmd_c45_i, cmd_op_i);
        case (q.st)
            HOST_IDLE: begin
                d.ready = 1'h1;
                if (cmd_valid_i && q.ready) begin
                    d.frame = {PRE_ONES, cmd_c45_i ? ST_C45 : ST_C22, cmd_op_i, cmd_phy_i, cmd_reg_i,
                               rd_n ? TA_RD_IDLE : TA_WR, rd_n ? RD_FILL : cmd_data_i};
                    d.rd = rd_n;
                    d.idx = cmd_pre_i ? IDX_PRE : IDX_NOPRE;
                    d.ready = 1'h0;
                    d.st = HOST_RUN;
                    d.div = DIV_RST;
                    d.mdc = 1'h0;
                    d.oe = host_drives(rd_n, d.idx);
                    d.out = tx_bit(d.frame, d.idx);
                end
            end
            HOST_RUN: begin
                d.div = q.div + 3'h1;
                if (q.div == MDC_HALF_LAST) begin
                    d.div = DIV_RST;
                    if (!q.mdc) begin
                        d.mdc = 1'h1;
                        if (q.rd && (q.idx >= DATA_START)) begin
                            d.rx = {q.rx[14:0], q.sync_s};
                        end
                        d.idx = q.idx + 7'h01;
                    end else begin
                        d.mdc = 1'h0;
                        if (q.idx == FRAME_BITS) begin
                            d.oe = 1'h0;
                            d.out = 1'h1;
                            d.st = HOST_DONE;
                        end else begin
                            d.oe = host_drives(q.rd, q.idx);
                            d.out = tx_bit(q.frame, q.idx);
                        end
                    end
                end
            end
            HOST_DONE: begin
                d.rsp_valid = 1'h1;
                d.rsp_data = q.rx;
                d.st = HOST_IDLE;
            end
            default: begin
                d = HOST_RST;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    assign link.mdc = q.mdc;
    assign link.host_mdio_oe = q.oe;
    assign link.host_mdio_o = q.out;
    assign cmd_ready_o = q.ready;
    assign rsp_valid_o = q.rsp_valid;
    assign rsp_data_o = q.rsp_data;
endmodule // mdsl_host_end
`default_nettype wire

// file: sim/mdsl_link_checker.sv
// Purpose: protocol checks on the wires between host end and device end
// Assumes: the bit clock is a slow product of clk_i, so clk_i sampling sees every edge
// Notes: the read span is counted in helper logic rather than with long repetitions
`timescale 1ns/1ps
`default_nettype none
module mdsl_link_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // link signals
    input wire logic mdc,
    input wire logic host_mdio_oe,
    input wire logic dev_mdio_o,
    input wire logic dev_mdio_oe
);
    // turnaround bit plus sixteen data bits, eight clocks each
    localparam logic [7:0] READ_SPAN = 8'h88;
    logic [7:0] span_q;

    ////////////////////////////////////////////////////////////////////////////
    // count clocks the device has held the line in the current read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            span_q <= 8'h00;
        end else begin
            span_q <= dev_mdio_oe ? span_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////////
    // contention would corrupt both ends, so the enables are never high together
    a_no_contention: assert property (!(host_mdio_oe && dev_mdio_oe))
        else $error("both ends drive the line");
    a_oe_on_fall: assert property ($changed(dev_mdio_oe) |-> $fell(mdc))
        else $error("device enable moved off a falling bit clock");
    a_data_on_fall: assert property ($changed(dev_mdio_o) |-> $fell(mdc))
        else $error("device data moved off a falling bit clock");
    a_ta_drives_zero: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o)
        else $error("device did not drive zero in second turnaround bit");
    a_ta1_floats: assert property ($fell(host_mdio_oe) |-> !dev_mdio_oe [*7])
        else $error("device drove during first turnaround bit");
    a_read_span: assert property ($fell(dev_mdio_oe) |-> span_q == READ_SPAN)
        else $error("device drove for a wrong number of clocks");
    a_idle_release: assert property ($fell(dev_mdio_oe) |-> !host_mdio_oe [*3])
        else $error("line not left idle after a read");
    a_frame_start_low: assert property ($rose(host_mdio_oe) |-> !mdc [*3])
        else $error("bit clock not low when a frame begins");

    // main scenarios seen
    c_read: cover property ($rose(dev_mdio_oe));
    c_frame: cover property ($rose(host_mdio_oe));
    c_release: cover property ($fell(host_mdio_oe));
endmodule // mdsl_link_checker
`default_nettype wire

// file: sim/tb_mdio_slave_frame_engine.sv
// Purpose: drives host and device ends against each other and judges the results
// Assumes: device port 13, device address 0A; bit clock is clk_i divided by eight
// Notes: write reports are counted by a monitor because they may precede the response
`timescale 1ns/1ps
`default_nettype none
module tb_mdio_slave_frame_engine;
    import mdsl_pkg::*;
    logic clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, cmd_c45_i, cmd_pre_i, rsp_valid_o, cfg_conn_i;
    logic wr_valid_o, wr_c45_o;
    logic [1:0] cmd_op_i;
    logic [ADDR_W-1:0] cmd_phy_i, cmd_reg_i, cfg_phy_i, cfg_dev_i;
    logic [DATA_W-1:0] cmd_data_i, rsp_data_o, wr_addr_o, wr_data_o, rd;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int wr_cnt = 0;
    mdsl_link_if link ();

    mdsl_host_end mdsl_host_end_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_c45_i(cmd_c45_i), .cmd_pre_i(cmd_pre_i), .cmd_op_i(cmd_op_i),
        .cmd_phy_i(cmd_phy_i), .cmd_reg_i(cmd_reg_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o));
    mdsl_dev_end mdsl_dev_end_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .cfg_phy_i(cfg_phy_i),
        .cfg_dev_i(cfg_dev_i), .cfg_conn_i(cfg_conn_i), .wr_valid_o(wr_valid_o), .wr_c45_o(wr_c45_o),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
    mdsl_link_checker mdsl_link_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .mdc(link.mdc),
        .host_mdio_oe(link.host_mdio_oe), .dev_mdio_o(link.dev_mdio_o), .dev_mdio_oe(link.dev_mdio_oe));

    ////////////////////////////////////////////////////////////////////////////
    // clock, hang guard and write report monitor
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wr_valid_o === 1'b1) wr_cnt <= wr_cnt + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one frame; waits for the response, then long enough for the write report
    task automatic cmd(input logic c45, input logic pre, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] dat);
        int n;
        @(posedge clk_i);
        {cmd_valid_i, cmd_c45_i, cmd_pre_i, cmd_op_i} <= {1'b1, c45, pre, op};
        {cmd_phy_i, cmd_reg_i, cmd_data_i} <= {phy, rg, dat};
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
        cmd_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp_valid_o !== 1'b1 && n < 700);
        chk("rsp_valid", {15'h0000, rsp_valid_o}, 16'h0001);
        rd = rsp_data_o;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic wchk(input int base, input logic c45, input logic [15:0] adr, input logic [15:0] dat);
        chk("wr_count", 16'(wr_cnt - base), 16'h0001);
        chk("wr_c45", {15'h0000, wr_c45_o}, {15'h0000, c45});
        chk("wr_addr", wr_addr_o, adr);
        chk("wr_data", wr_data_o, dat);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // short format write then reads of that register and a neighbour
    task automatic t_short;
        int b;
        b = wr_cnt;
        cmd(1'b0, 1'b1, OP22_WR, 5'h13, 5'h1D, 16'hA5C3);
        wchk(b, 1'b0, 16'h001D, 16'hA5C3);
        cmd(1'b0, 1'b1, OP22_RD, 5'h13, 5'h1D, 16'h0000);
        chk("short_read", rd, 16'hA5C3);
        cmd(1'b0, 1'b1, OP22_RD, 5'h13, 5'h1C, 16'h0000);
        chk("short_read_other", rd, 16'h0000);
    endtask

    // frames the device must ignore, and the connector port zero option
    task automatic t_refuse;
        int b;
        b = wr_cnt;
        cmd(1'b0, 1'b1, OP22_WR, 5'h12, 5'h1D, 16'h0F0F);
        chk("mismatch_write", 16'(wr_cnt - b), 16'h0000);
        cmd(1'b0, 1'b1, OP22_RD, 5'h12, 5'h1D, 16'h0000);
        chk("mismatch_read", rd, 16'hFFFF);
        cmd(1'b0, 1'b0, OP22_RD, 5'h13, 5'h1D, 16'h0000);
        chk("no_preamble", rd, 16'hFFFF);
        cmd(1'b0, 1'b1, OP22_RD, 5'h00, 5'h1D, 16'h0000);
        chk("port_zero_off", rd, 16'hFFFF);
        cfg_conn_i <= 1'b1;
        cmd(1'b0, 1'b1, OP22_RD, 5'h00, 5'h1D, 16'h0000);
        chk("port_zero_on", rd, 16'hA5C3);
        cfg_conn_i <= 1'b0;
    endtask

    // long format: address frames, write, read with increment, plain read
    task automatic t_long;
        int b;
        b = wr_cnt;
        cmd(1'b1, 1'b1, OP45_ADDR, 5'h13, 5'h0A, 16'h0007);
        chk("addr_no_write", 16'(wr_cnt - b), 16'h0000);
        cmd(1'b1, 1'b1, OP45_WR, 5'h13, 5'h0A, 16'h1234);
        wchk(b, 1'b1, 16'h0007, 16'h1234);
        cmd(1'b1, 1'b1, OP45_ADDR, 5'h13, 5'h0A, 16'h0008);
        cmd(1'b1, 1'b1, OP45_WR, 5'h13, 5'h0A, 16'h5678);
        cmd(1'b1, 1'b1, OP45_ADDR, 5'h13, 5'h0A, 16'h0007);
        cmd(1'b1, 1'b1, OP45_RDINC, 5'h13, 5'h0A, 16'h0000);
        chk("read_inc", rd, 16'h1234);
        cmd(1'b1, 1'b1, OP45_RD, 5'h13, 5'h0A, 16'h0000);
        chk("read_after_inc", rd, 16'h5678);
        cmd(1'b1, 1'b1, OP45_RD, 5'h13, 5'h0B, 16'h0000);
        chk("dev_mismatch", rd, 16'hFFFF);
    endtask

    task automatic final_report;
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        // nonblocking so every asynchronous reset sees the falling edge at time zero
        {rst_n_i, cmd_valid_i, cmd_c45_i, cmd_pre_i, cmd_op_i, cfg_conn_i} <= 7'h00;
        {cmd_phy_i, cmd_reg_i, cmd_data_i} = 26'h000_0000;
        cfg_phy_i = 5'h13;
        cfg_dev_i = 5'h0A;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_short();
        t_refuse();
        t_long();
        final_report();
    end
endmodule // tb_mdio_slave_frame_engine
`default_nettype wire
